// [hdl/rtcc_top.sv]
// How it works
// - Hour counter BCD, 1..12 in twelve-hour mode, 0..23 otherwise
// - Half-day flag at bit 14, one means afternoon
// - In 24-hour mode flag reads zero and writing one is ignored
// - Stale flag after switch to 24-hour clears at next hour step
// - Minute counter BCD 0..59
// - Month counter BCD 1..12
// - Day counter BCD 1..month length, leap February has 29
// - Weekday counts 0..6, Sunday is 0
// - Year counter BCD 0..99
// - Flags set on cause, write one clears, zero keeps
// - Bits 15..12 regulation and stopwatch, 11..9 read zero
// - Bits 8..0 alarm, day, hour, minute and sub-minute ticks
// - Enable bits read/write, one lets the cause through
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_map.svh"

module rtcc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // From the seconds stage, same clock
  input  wire logic              minute_carry,
  input  wire logic              clock_busy,
  input  wire rtcc_pkg::rtcc_evt_t events,
  // Interrupt request
  output var  logic              irq
);

  // ============================================================
  // Parameter check
  if (ADDR_W < 5)
  begin : g_bad_addr
    $error("rtcc_top: ADDR_W too small for the register map");
  end

  // ============================================================
  // BCD helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9)
    begin
      r = {v[7:4] + 4'h1, 4'h0};
    end
    else
    begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  rtcc_pkg::rtcc_cal_t cal;
  logic                twentyfour_hour_select;
  logic [15:0]         int_flags;
  logic [15:0]         int_enables;

  // ============================================================
  // Bus decode
  logic              acc_phase;
  logic              wr_now;
  logic [ADDR_W-1:0] wr_addr;
  logic              known_addr;
  assign acc_phase = psel & penable & ~pready;
  // Write lands only on the edge that completes the transfer
  assign wr_now    = psel & penable & pready & pwrite;
  assign wr_addr   = paddr;
  always_comb
  begin
    case (paddr)
      ADDR_W'(`RTCC_OFS_HOUR_MIN),
      ADDR_W'(`RTCC_OFS_MONTH_DAY),
      ADDR_W'(`RTCC_OFS_YEAR_WEEK),
      ADDR_W'(`RTCC_OFS_INT_FLAGS),
      ADDR_W'(`RTCC_OFS_INT_ENABLE),
      ADDR_W'(`RTCC_OFS_CONTROL): known_addr = 1'b1;
      default:                    known_addr = 1'b0;
    endcase
  end

  logic wr_hm;
  logic wr_md;
  logic wr_yw;
  logic wr_if;
  logic wr_ie;
  logic wr_ct;
  assign wr_hm = wr_now & (wr_addr == ADDR_W'(`RTCC_OFS_HOUR_MIN));
  assign wr_md = wr_now & (wr_addr == ADDR_W'(`RTCC_OFS_MONTH_DAY));
  assign wr_yw = wr_now & (wr_addr == ADDR_W'(`RTCC_OFS_YEAR_WEEK));
  assign wr_if = wr_now & (wr_addr == ADDR_W'(`RTCC_OFS_INT_FLAGS));
  assign wr_ie = wr_now & (wr_addr == ADDR_W'(`RTCC_OFS_INT_ENABLE));
  assign wr_ct = wr_now & (wr_addr == ADDR_W'(`RTCC_OFS_CONTROL));

  // ============================================================
  // Calendar cascade
  logic [7:0] minute_bcd;
  logic [7:0] hour_bcd;
  logic [7:0] day_bcd;
  logic [7:0] month_bcd;
  logic [7:0] year_bcd;
  logic [7:0] last_day;
  logic       leap_year;
  logic       minute_wrap;
  logic       day_wrap;
  logic       month_wrap;
  assign minute_bcd = {1'b0, cal.minute_tens, cal.minute_units};
  assign hour_bcd   = {2'b00, cal.hour_tens, cal.hour_units};
  assign day_bcd    = {2'b00, cal.day_tens, cal.day_units};
  assign month_bcd  = {3'b000, cal.month_tens, cal.month_units};
  assign year_bcd   = {cal.year_tens, cal.year_units};

  // leap test
  // Year 00 counts as leap; the range holds no century exception
  assign leap_year = cal.year_tens[0]
                   ? ((cal.year_units == 4'h2) | (cal.year_units == 4'h6))
                   : ((cal.year_units == 4'h0) | (cal.year_units == 4'h4)
                     | (cal.year_units == 4'h8));

  always_comb
  begin
    case (month_bcd)
      8'h02:   last_day = leap_year ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  end

  assign minute_wrap = minute_carry & (minute_bcd == 8'h59);
  // day ends at midnight in either format
  assign day_wrap = minute_wrap & (twentyfour_hour_select ? (hour_bcd == 8'h23)
                                   : ((hour_bcd == 8'h11) & cal.half_day_flag));
  assign month_wrap = day_wrap & (day_bcd >= last_day);

  // Minute counter; bus writes win, software avoids writes while busy
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cal.minute_tens  <= 3'h0;
      cal.minute_units <= 4'h0;
    end
    else if (wr_hm)
    begin
      cal.minute_tens  <= pwdata[6:4];
      cal.minute_units <= pwdata[3:0];
    end
    else if (minute_carry)
    begin
      {cal.minute_tens, cal.minute_units} <=
        minute_wrap ? 7'h00 : 7'(bcd_inc(minute_bcd));
    end
  end

  // Hour counter and half-day flag
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cal.hour_tens     <= `RTCC_RST_HOUR_TENS;
      cal.hour_units    <= `RTCC_RST_HOUR_UNITS;
      cal.half_day_flag <= 1'b0;
    end
    else if (wr_hm)
    begin
      cal.hour_tens     <= pwdata[13:12];
      cal.hour_units    <= pwdata[11:8];
      // writing one is ignored in 24-hour mode
      cal.half_day_flag <= pwdata[`RTCC_BIT_HALF_DAY]
                         & ~twentyfour_hour_select;
    end
    else if (minute_wrap)
    begin
      if (twentyfour_hour_select)
      begin
        // stale flag cleared on hour step
        cal.half_day_flag <= 1'b0;
        {cal.hour_tens, cal.hour_units} <=
          (hour_bcd == 8'h23) ? 6'h00 : 6'(bcd_inc(hour_bcd));
      end
      else
      begin
        // 11 to 12 flips morning and afternoon
        if (hour_bcd == 8'h11)
        begin
          cal.half_day_flag <= ~cal.half_day_flag;
        end
        {cal.hour_tens, cal.hour_units} <=
          (hour_bcd == 8'h12) ? 6'h01 : 6'(bcd_inc(hour_bcd));
      end
    end
  end

  // Day, weekday, month and year
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cal.day_tens      <= 2'h0;
      cal.day_units     <= `RTCC_RST_DAY_UNITS;
      {cal.month_tens, cal.month_units} <= `RTCC_RST_MONTH;
      cal.weekday_count <= 3'h0;
      cal.year_tens     <= 4'h0;
      cal.year_units    <= 4'h0;
    end
    else
    begin
      if (wr_md)
      begin
        {cal.month_tens, cal.month_units} <= pwdata[12:8];
        cal.day_tens  <= pwdata[5:4];
        cal.day_units <= pwdata[3:0];
      end
      else if (day_wrap)
      begin
        {cal.day_tens, cal.day_units} <=
          month_wrap ? 6'h01 : 6'(bcd_inc(day_bcd));
        if (month_wrap)
        begin
          {cal.month_tens, cal.month_units} <=
            (month_bcd == 8'h12) ? 5'h01 : 5'(bcd_inc(month_bcd));
        end
      end
      if (wr_yw)
      begin
        cal.weekday_count <= pwdata[10:8];
        cal.year_tens     <= pwdata[7:4];
        cal.year_units    <= pwdata[3:0];
      end
      else
      begin
        if (day_wrap)
        begin
          cal.weekday_count <= (cal.weekday_count == 3'h6) ? 3'h0
                             : cal.weekday_count + 3'h1;
        end
        if (month_wrap & (month_bcd == 8'h12))
        begin
          {cal.year_tens, cal.year_units} <=
            (year_bcd == 8'h99) ? 8'h00 : bcd_inc(year_bcd);
        end
      end
    end
  end

  // ============================================================
  // Control register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      twentyfour_hour_select <= 1'b0;
    end
    else if (wr_ct)
    begin
      twentyfour_hour_select <= pwdata[`RTCC_BIT_24H];
    end
  end

  // ============================================================
  // Interrupts
  logic [15:0] cause;
  // lower causes: alarm from the inputs, day and hour ticks from the cascade, then minute and second ticks from the inputs
  assign cause = {events.regulation_done, events.stopwatch_1hz,
                  events.stopwatch_10hz, events.stopwatch_100hz,
                  3'b000, events.alarm,
                  day_wrap, minute_wrap, minute_carry,
                  events.second_tick, events.half_second_tick,
                  events.quarter_second_tick, events.eighth_second_tick,
                  events.thirtysecond_second_tick};

  // Sticky flags; a cause in the clearing cycle still sets
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      int_flags <= 16'h0000;
    end
    else
    begin
      int_flags <= ((int_flags & ~(wr_if ? pwdata[15:0] : 16'h0000))
                   | cause) & `RTCC_INT_MASK;
    end
  end

  // Enable register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      int_enables <= 16'h0000;
    end
    else if (wr_ie)
    begin
      int_enables <= pwdata[15:0] & `RTCC_INT_MASK;
    end
  end

  // Request follows flags one cycle later, straight from a flop
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(int_flags & int_enables);
    end
  end

  // ============================================================
  // Read mux
  logic [15:0] rd_word;
  always_comb
  begin
    case (paddr)
      ADDR_W'(`RTCC_OFS_HOUR_MIN):
        // flag reads zero in 24-hour mode
        rd_word = {1'b0, cal.half_day_flag & ~twentyfour_hour_select,
                   cal.hour_tens, cal.hour_units, 1'b0,
                   cal.minute_tens, cal.minute_units};
      ADDR_W'(`RTCC_OFS_MONTH_DAY):
        rd_word = {3'b000, cal.month_tens, cal.month_units, 2'b00,
                   cal.day_tens, cal.day_units};
      ADDR_W'(`RTCC_OFS_YEAR_WEEK):
        rd_word = {5'b00000, cal.weekday_count, cal.year_tens,
                   cal.year_units};
      ADDR_W'(`RTCC_OFS_INT_FLAGS):  rd_word = int_flags;
      ADDR_W'(`RTCC_OFS_INT_ENABLE): rd_word = int_enables;
      ADDR_W'(`RTCC_OFS_CONTROL):
        rd_word = {14'h0000, clock_busy, twentyfour_hour_select};
      default:                       rd_word = 16'h0000;
    endcase
  end

  // One wait state: answer in the second access cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc_phase;
      pslverr <= acc_phase & ~known_addr;
      if (acc_phase & ~pwrite)
      begin
        prdata <= {16'h0000, rd_word};
      end
    end
  end

endmodule // rtcc_top

`default_nettype wire

// [hdl/rtcc_map.svh]
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH
// ==============================================================
// Register offsets (byte addresses)
`define RTCC_OFS_HOUR_MIN   8'h00
`define RTCC_OFS_MONTH_DAY  8'h04
`define RTCC_OFS_YEAR_WEEK  8'h08
`define RTCC_OFS_INT_FLAGS  8'h0C
`define RTCC_OFS_INT_ENABLE 8'h10
`define RTCC_OFS_CONTROL    8'h14
// ==============================================================
// Field positions
`define RTCC_BIT_HALF_DAY   14
`define RTCC_BIT_24H        0
`define RTCC_BIT_BUSY       1
`define RTCC_BIT_DAY_TICK   7
`define RTCC_BIT_HOUR_TICK  6
`define RTCC_BIT_MIN_TICK   5
// Implemented interrupt bits; 11..9 reserved
`define RTCC_INT_MASK       16'hF1FF
// ==============================================================
// Reset values
`define RTCC_RST_HOUR_TENS  2'h1
`define RTCC_RST_HOUR_UNITS 4'h2
`define RTCC_RST_MONTH      5'h01
`define RTCC_RST_DAY_UNITS  4'h1
`endif

// [hdl/rtcc_pkg.sv]
package rtcc_pkg;
  // Calendar counters, one packed word
  typedef struct packed {
    logic       half_day_flag;
    logic [1:0] hour_tens;
    logic [3:0] hour_units;
    logic [2:0] minute_tens;
    logic [3:0] minute_units;
    logic       month_tens;
    logic [3:0] month_units;
    logic [1:0] day_tens;
    logic [3:0] day_units;
    logic [2:0] weekday_count;
    logic [3:0] year_tens;
    logic [3:0] year_units;
  } rtcc_cal_t;
  // Interrupt causes from the rest of the clock
  typedef struct packed {
    logic regulation_done;
    logic stopwatch_1hz;
    logic stopwatch_10hz;
    logic stopwatch_100hz;
    logic alarm;
    logic second_tick;
    logic half_second_tick;
    logic quarter_second_tick;
    logic eighth_second_tick;
    logic thirtysecond_second_tick;
  } rtcc_evt_t;
endpackage : rtcc_pkg

// [verif/rtcc_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks for the calendar block
module rtcc_top_sva #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset,
  // Bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Causes and interrupt
  input wire logic              minute_carry,
  input wire logic              clock_busy,
  input wire rtcc_pkg::rtcc_evt_t events,
  input wire logic              irq
);
  logic cause;
  logic wr_done;
  logic rd_done;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Anything that may raise a flag or open an enable
  assign cause   = (|events) | minute_carry | wr_done;
  assign wr_done = pready & pwrite;
  assign rd_done = pready & ~pwrite;
  // One wait state, then a single-cycle ready
  property p_one_wait;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready timing off");
  property p_err_quiet;
    pslverr |-> pready && (pwrite || prdata == 32'h0000_0000);
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error response off");
  property p_resv_irq;
    rd_done && (paddr == 8'h0C || paddr == 8'h10) |-> prdata[31:16] == 0 && prdata[11:9] == 0;
  endproperty
  a_resv_irq: assert property (p_resv_irq) else $error("reserved irq bits");
  property p_hm_bcd;
    rd_done && paddr == 8'h00 |-> !prdata[15] && !prdata[7] && prdata[13:12] <= 2
      && prdata[6:4] <= 5 && prdata[3:0] <= 9;
  endproperty
  a_hm_bcd: assert property (p_hm_bcd) else $error("hour or minute out of range");
  property p_mon;
    rd_done && paddr == 8'h04 |-> prdata[12:8] inside {[5'h01:5'h09], [5'h10:5'h12]};
  endproperty
  a_mon: assert property (p_mon) else $error("month out of range");
  property p_wk;
    rd_done && paddr == 8'h08 |-> prdata[10:8] <= 6 && prdata[15:11] == 0;
  endproperty
  a_wk: assert property (p_wk) else $error("weekday out of range");
  property p_irq_rise;
    $rose(irq) |-> $past(cause, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall;
    $fell(irq) |-> $past(wr_done, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule // rtcc_top_sva
`default_nettype wire

// [verif/test_rtcc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_rtcc_top;
  logic                clk = 1'b0;
  logic                reset = 1'b1;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0000_0000;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                minute_carry = 1'b0;
  logic                clock_busy = 1'b0;
  rtcc_pkg::rtcc_evt_t events = '0;
  logic                irq;
  int                  error_cnt = 0;
  int                  checks = 0;
  // ==========
  // Clock and design
  always #50 clk = ~clk;
  rtcc_top DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .minute_carry(minute_carry), .clock_busy(clock_busy), .events(events), .irq(irq));
  // ==========
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // One transfer; a lost ready counts as a mismatch
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      $display("wrong value pready exp 1 got %b", pready);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counters only written with the busy line low
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {16'h0000, d}, q, e);
  endtask
  // Each counter read is taken twice and both must match
  task automatic rd(input logic [7:0] a, input logic [15:0] x, input string nm);
    logic [31:0] q;
    logic        e;
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk(nm, {16'h0000, x}, q);
    end
  endtask
  task automatic pulse(input logic [9:0] e, input logic mc);
    @(posedge clk);
    events       <= e;
    minute_carry <= mc;
    @(posedge clk);
    events       <= '0;
    minute_carry <= 1'b0;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    rd(8'h00, 16'h1200, "hm");
    rd(8'h04, 16'h0101, "md");
    rd(8'h08, 16'h0000, "yw");
    rd(8'h0C, 16'h0000, "flg");
    rd(8'h10, 16'h0000, "ena");
    clock_busy <= 1'b1;
    rd(8'h14, 16'h0002, "ctl");
    clock_busy <= 1'b0;
    apb(1'b0, 8'h18, 32'h0000_0000, q, e);
    chk("err", 32'h1, {31'h0, e});
    chk("errq", 32'h0, q);
  endtask
  task automatic t_flags();
    int pos[10] = '{0, 1, 2, 3, 4, 8, 12, 13, 14, 15};
    for (int i = 0; i < 10; i++)
    begin
      pulse(10'h001 << i, 1'b0);
      rd(8'h0C, 16'h0001 << pos[i], "flg");
      wr(8'h0C, 16'h0001 << pos[i]);
    end
    pulse(10'h3FF, 1'b0);
    wr(8'h0C, 16'h0000);
    rd(8'h0C, 16'hF11F, "flg");
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h10, 16'h0100);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h10, 16'hFFFF);
    rd(8'h10, 16'hF1FF, "ena");
    wr(8'h0C, 16'hF11E);
    rd(8'h0C, 16'h0001, "flg");
    wr(8'h0C, 16'h0001);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
  endtask
  task automatic t_cascade();
    wr(8'h14, 16'h0001);
    wr(8'h10, 16'h00E0);
    wr(8'h00, 16'h2359);
    wr(8'h04, 16'h1231);
    wr(8'h08, 16'h0699);
    pulse(10'h000, 1'b1);
    rd(8'h00, 16'h0000, "hm");
    rd(8'h04, 16'h0101, "md");
    rd(8'h08, 16'h0000, "yw");
    rd(8'h0C, 16'h00E0, "flg");
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h10, 16'h0000);
  endtask
  task automatic t_halfday();
    logic [15:0] tab[4][2] = '{'{16'h5159, 16'h1200}, '{16'h1159, 16'h5200},
                               '{16'h5259, 16'h4100}, '{16'h0959, 16'h1000}};
    wr(8'h14, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, tab[i][0]);
      pulse(10'h000, 1'b1);
      rd(8'h00, tab[i][1], "hm12");
    end
    wr(8'h00, 16'h4159);
    wr(8'h14, 16'h0001);
    rd(8'h00, 16'h0159, "hm24");
    wr(8'h14, 16'h0000);
    rd(8'h00, 16'h4159, "hm12");
    wr(8'h14, 16'h0001);
    pulse(10'h000, 1'b1);
    wr(8'h14, 16'h0000);
    rd(8'h00, 16'h0200, "hm12");
    wr(8'h14, 16'h0001);
    wr(8'h00, 16'h4300);
    wr(8'h14, 16'h0000);
    rd(8'h00, 16'h0300, "hm12");
  endtask
  task automatic t_month_ends();
    logic [15:0] tab[7][3] = '{'{16'h0024, 16'h0228, 16'h0229},
      '{16'h0024, 16'h0229, 16'h0301}, '{16'h0023, 16'h0228, 16'h0301},
      '{16'h0000, 16'h0228, 16'h0229}, '{16'h0023, 16'h0430, 16'h0501},
      '{16'h0023, 16'h0930, 16'h1001}, '{16'h0023, 16'h0131, 16'h0201}};
    wr(8'h14, 16'h0001);
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h00, 16'h2359);
      wr(8'h04, tab[i][1]);
      wr(8'h08, tab[i][0]);
      pulse(10'h000, 1'b1);
      rd(8'h04, tab[i][2], "md");
      rd(8'h08, tab[i][0] + 16'h0100, "yw");
    end
  endtask
  // ==========
  // Verdict, reached from the main sequence or the watchdog
  task automatic tally_and_finish();
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_flags();
    t_cascade();
    t_halfday();
    t_month_ends();
    tally_and_finish();
  end
  // Whole run needs well under a thousand transfers
  initial
  begin
    #1_000_000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // test_rtcc_top
bind rtcc_top rtcc_top_sva #(.ADDR_W(ADDR_W)) u_sva (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .minute_carry(minute_carry),
  .clock_busy(clock_busy), .events(events), .irq(irq));
`default_nettype wire
